// *** rtl/tfh_consts.vh ***
// register map, field positions and timing constants for the two-wire flag block
`ifndef TFH_CONSTS_VH
`define TFH_CONSTS_VH
`define TFH_ADR_CTRL      4'h0
`define TFH_ADR_SSTAT     4'h4
`define TFH_ADR_SCMD      4'h8
`define TFH_ADR_MSTAT     4'hC
// slave status bits
`define TFH_SS_ADDRESS_STOP_IRQ_FLAG       7
`define TFH_SS_DIF        6
`define TFH_SS_HOLD       5
`define TFH_SS_COLL       3
`define TFH_SS_AP         0
// control bits
`define TFH_CT_EN         0
`define TFH_CT_TOEN       1
// bus state encoding
`define TFH_BS_IDLE       2'h1
`define TFH_BS_BUSY       2'h3
`define TFH_BS_UNK        2'h0
// bit count that ends an address or data byte
`define TFH_BIT_LAST      4'h8
`define TFH_CMD_RESP      2'h3
`define TFH_TO_DEF        16'h0200
`define TFH_ADDR_DEF      7'h2A
`endif

// *** rtl/tfh_core.v ***
// two-wire slave status flags, clock stretching and wishbone register slave
//
// The Wishbone interface to the registers and the register addresses were decided locally.
`include "tfh_consts.vh"
// Contract
// - collision flag auto-clears only on start, not on repeated start.
// - new address sets address/stop flag and stretches scl until handled.
// - clear in same cycle as address set leaves scl held; bus locks.
// - timeout coinciding with start detection drops that transaction.
// - response command 0b11 clears data flag one cycle late.
module tfh_core #(
    parameter [15:0] TIMEOUT_CYC = `TFH_TO_DEF,
    parameter [6:0]  OWN_ADDR    = `TFH_ADDR_DEF
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire [3:0]  adr_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    input  wire        we_i,
    input  wire [3:0]  sel_i,
    input  wire        cyc_i,
    input  wire        stb_i,
    output wire        ack_o,
    input  wire        scl_i,
    input  wire        sda_i,
    output wire        scl_o,
    output wire        scl_oe_o,
    output wire        sda_o,
    output wire        sda_oe_o
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    reg [1:0] scl_s_r;
    reg [1:0] sda_s_r;
    reg       scl_d_r;
    reg       sda_d_r;
    always @(posedge clk_i) begin
        if (rst_i) begin
            scl_s_r <= 2'h3;
            sda_s_r <= 2'h3;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_s_r <= {scl_s_r[0], scl_i};
            sda_s_r <= {sda_s_r[0], sda_i};
            scl_d_r <= scl_s_r[1];
            sda_d_r <= sda_s_r[1];
        end
    end
    wire scl_w    = scl_s_r[1];
    wire sda_w    = sda_s_r[1];
    wire start_w  = scl_w & scl_d_r & sda_d_r & ~sda_w;
    wire stop_w   = scl_w & scl_d_r & ~sda_d_r & sda_w;
    wire scl_rise = scl_w & ~scl_d_r;
    wire scl_fall = ~scl_w & scl_d_r;

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    reg  ack_r;
    wire req_w = cyc_i & stb_i & ~ack_r;
    wire wr_w  = req_w & we_i & sel_i[0];
    assign ack_o = ack_r;
    reg  [1:0] ctrl_r;
    reg  [1:0] bus_state_field_r;
    reg        address_stop_irq_flag_r;
    reg        data_irq_flag_r;
    reg        scl_stretch_flag_r;
    reg        coll_r;
    reg        ap_r;
    reg        dif_clr_r;
    wire wr_sstat = wr_w & (adr_i == `TFH_ADR_SSTAT);
    wire wr_scmd  = wr_w & (adr_i == `TFH_ADR_SCMD);
    wire sw_apclr = wr_sstat & dat_i[`TFH_SS_ADDRESS_STOP_IRQ_FLAG];
    wire resp_cmd = wr_scmd & (dat_i[1:0] == `TFH_CMD_RESP);
    reg  [31:0] rd_mux_nxt;
    always @* begin
        rd_mux_nxt = 32'h0000_0000;
        if (adr_i == `TFH_ADR_CTRL)
            rd_mux_nxt = {30'h0, ctrl_r};
        else if (adr_i == `TFH_ADR_SSTAT)
            rd_mux_nxt = {24'h0, address_stop_irq_flag_r, data_irq_flag_r,
                          scl_stretch_flag_r, 1'b0, coll_r, 2'h0, ap_r};
        else if (adr_i == `TFH_ADR_MSTAT)
            rd_mux_nxt = {30'h0, bus_state_field_r};
        else
            rd_mux_nxt = 32'h0000_0000;
    end
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_r  <= 1'b0;
            dat_o  <= 32'h0000_0000;
            ctrl_r <= 2'h0;
        end else begin
            ack_r <= req_w;
            if (wr_w && adr_i == `TFH_ADR_CTRL)
                ctrl_r <= dat_i[1:0];
            if (req_w && !we_i)
                dat_o <= rd_mux_nxt;
        end
    end
    wire en_w   = ctrl_r[`TFH_CT_EN];
    wire toen_w = ctrl_r[`TFH_CT_TOEN];

    // ------------------------------------------------------------
    // bus state and timeout
    // ------------------------------------------------------------
    reg [15:0] to_cnt_r;
    wire to_fire = toen_w & (to_cnt_r == TIMEOUT_CYC) & (bus_state_field_r != `TFH_BS_IDLE);
    reg busy_r;
    // any scl edge, start or stop restarts the count; it saturates at the limit
    always @(posedge clk_i) begin
        if (rst_i)
            to_cnt_r <= 16'h0000;
        else if (scl_rise || scl_fall || start_w || stop_w)
            to_cnt_r <= 16'h0000;
        else if (to_cnt_r != TIMEOUT_CYC)
            to_cnt_r <= to_cnt_r + 16'h0001;
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            bus_state_field_r <= `TFH_BS_UNK;
            busy_r            <= 1'b0;
        end else begin
            if (!en_w)
                bus_state_field_r <= `TFH_BS_UNK;
            else if (start_w)
                bus_state_field_r <= `TFH_BS_BUSY;
            else if (stop_w || to_fire || bus_state_field_r == `TFH_BS_UNK)
                bus_state_field_r <= `TFH_BS_IDLE;
            busy_r <= bus_state_field_r == `TFH_BS_BUSY;
        end
    end

    // ------------------------------------------------------------
    // slave receive engine
    // ------------------------------------------------------------
    localparam ST_IDLE = 4'b0001;
    localparam ST_ADDR = 4'b0010;
    localparam ST_ACK  = 4'b0100;
    localparam ST_DATA = 4'b1000;
    reg [3:0] st_r;
    reg [3:0] bit_r;
    reg [7:0] shf_r;
    reg       sda_drv_r;
    wire drop_w = start_w & to_fire;
    wire addr_match = (shf_r[7:1] == OWN_ADDR);
    wire addr_set = (st_r == ST_ADDR) & scl_fall & (bit_r == `TFH_BIT_LAST) & addr_match;
    always @(posedge clk_i) begin
        if (rst_i) begin
            st_r      <= ST_IDLE;
            bit_r     <= 4'h0;
            shf_r     <= 8'h00;
            sda_drv_r <= 1'b0;
        end else if (!en_w || stop_w || to_fire) begin
            st_r      <= ST_IDLE;
            sda_drv_r <= 1'b0;
        end else if (start_w) begin
            st_r  <= drop_w ? ST_IDLE : ST_ADDR;
            bit_r <= 4'h0;
        end else begin
            case (st_r)
                ST_ADDR, ST_DATA: begin
                    if (scl_rise && bit_r != `TFH_BIT_LAST) begin
                        shf_r <= {shf_r[6:0], sda_w};
                        bit_r <= bit_r + 4'h1;
                    end else if (scl_fall && bit_r == `TFH_BIT_LAST) begin
                        if (st_r == ST_ADDR && !addr_match)
                            st_r <= ST_IDLE;
                        else begin
                            st_r      <= ST_ACK;
                            sda_drv_r <= 1'b1;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall && !scl_stretch_flag_r) begin
                        sda_drv_r <= 1'b0;
                        bit_r     <= 4'h0;
                        st_r      <= ST_DATA;
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end
    wire data_set = (st_r == ST_DATA) & scl_fall & (bit_r == `TFH_BIT_LAST);
    wire stop_ap  = stop_w & (st_r != ST_IDLE);

    // ------------------------------------------------------------
    // address/stop flag
    // ------------------------------------------------------------
    // set wins: a clear landing in the set cycle is simply lost
    always @(posedge clk_i) begin
        if (rst_i) begin
            address_stop_irq_flag_r <= 1'b0;
            ap_r                    <= 1'b0;
        end else begin
            if (addr_set) begin
                address_stop_irq_flag_r <= 1'b1;
                ap_r                    <= 1'b1;
            end else if (stop_ap) begin
                address_stop_irq_flag_r <= 1'b1;
                ap_r                    <= 1'b0;
            end else if (sw_apclr) begin
                address_stop_irq_flag_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // clock hold
    // ------------------------------------------------------------
    // hold survives a colliding clear, so scl stays low and the bus locks
    always @(posedge clk_i) begin
        if (rst_i)
            scl_stretch_flag_r <= 1'b0;
        else if (addr_set || data_set)
            scl_stretch_flag_r <= 1'b1;
        else if (!stop_ap && (sw_apclr || dif_clr_r))
            scl_stretch_flag_r <= 1'b0;
    end

    // ------------------------------------------------------------
    // data flag
    // ------------------------------------------------------------
    // the response command acts one cycle late, at the ack edge; no read can land in between, so the next read sees the flag clear
    always @(posedge clk_i) begin
        if (rst_i) begin
            data_irq_flag_r <= 1'b0;
            dif_clr_r       <= 1'b0;
        end else begin
            if (data_set)
                data_irq_flag_r <= 1'b1;
            else if (dif_clr_r)
                data_irq_flag_r <= 1'b0;
            if (data_set)
                dif_clr_r <= 1'b0;
            else
                dif_clr_r <= resp_cmd;
        end
    end

    // ------------------------------------------------------------
    // transmit collision flag
    // ------------------------------------------------------------
    // drive delayed by the synchroniser depth, else every ack start
    // would compare against the stale high level and flag a collision
    reg [1:0] drv_d_r;
    always @(posedge clk_i) begin
        if (rst_i) begin
            drv_d_r <= 2'h0;
            coll_r  <= 1'b0;
        end else begin
            drv_d_r <= {drv_d_r[0], sda_drv_r};
            // only a start from idle or a write of the COLL bit clears; repeated start keeps it
            if (drv_d_r[1] & sda_drv_r & sda_w)
                coll_r <= 1'b1;
            else if (start_w && !busy_r)
                coll_r <= 1'b0;
            else if (wr_sstat && dat_i[`TFH_SS_COLL])
                coll_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------

    // open drain: drive low only
    assign scl_o    = 1'b0;
    assign scl_oe_o = scl_stretch_flag_r & ~scl_w;
    assign sda_o    = 1'b0;
    assign sda_oe_o = sda_drv_r;
endmodule // tfh_core

// *** bench/tfh_checker.sv ***
// assertions on the ports of the two-wire flag block
module tfh_checker (
    input wire        clk_i,
    input wire        rst_i,
    input wire [31:0] dat_o,
    input wire        we_i,
    input wire        cyc_i,
    input wire        stb_i,
    input wire        ack_o,
    input wire        scl_oe_o,
    input wire        sda_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take; cyc_i && stb_i && !ack_o; endsequence
    sequence s_answer; s_take ##1 ack_o; endsequence
    a_ack_follows: assert property (s_take |=> ack_o) else $error("request not answered");
    a_ack_single: assert property (s_answer |=> !ack_o) else $error("ack too long");
    a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack unasked");
    a_reset_quiet: assert property ($fell(rst_i) |-> !(ack_o || scl_oe_o || sda_oe_o))
        else $error("output active after reset");
    a_read_upper: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    a_stretch_held: assert property (scl_oe_o && !(cyc_i && stb_i && we_i) |=> scl_oe_o)
        else $error("stretch dropped early");
    a_stretch_release: assert property ($fell(scl_oe_o) |-> $past(cyc_i && stb_i && we_i))
        else $error("stretch dropped without write");
endmodule // tfh_checker
bind tfh_core tfh_checker i_tfh_checker (.clk_i, .rst_i, .dat_o, .we_i, .cyc_i, .stb_i, .ack_o,
    .scl_oe_o, .sda_oe_o);

// *** bench/tfh_rmt_master.sv ***
// remote two-wire master: start, two bytes, stop
module tfh_rmt_master (
    input  wire  scl_i,
    input  wire  sda_i,
    output logic scl_rel_o = 1'b1,
    output logic sda_rel_o = 1'b1
);
    timeunit 1ns;
    timeprecision 100ps;
    int n;
    task automatic frame(input logic [17:0] bits, output logic ack);
        sda_rel_o = 1'b0;
        #62.5;
        for (int i = 17; i >= -1; i--) begin
            scl_rel_o = 1'b0;
            #31.2;
            sda_rel_o = (i >= 0) ? bits[i] : 1'b0;
            #31.2;
            scl_rel_o = 1'b1;
            // a held clock is waited out; bounded so a locked bus cannot hang
            for (n = 0; n < 900 && scl_i !== 1'b1; n++)
                #9.7;
            #62.5;
            if (i == 9)
                ack = (n < 900) ? sda_i : 1'b1;
        end
        sda_rel_o = 1'b1;
        #62.5;
    endtask
endmodule // tfh_rmt_master

// *** bench/tb.sv ***
// self-checking bench for the two-wire flag block
`include "tfh_consts.vh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic [7:0]  q;
    logic        ack, scl_oe, sda_oe, scl_rel, sda_rel, a0;
    wire         scl = scl_rel & ~scl_oe;
    wire         sda = sda_rel & ~sda_oe;
    int          num_errors = 0, n_checks = 0;
    always #4 clk = ~clk;
    tfh_core i_tfh_core (.clk_i(clk), .rst_i(rst), .adr_i(adr), .dat_i(wdat), .dat_o(rdat),
        .we_i(we), .sel_i(4'h1), .cyc_i(cyc), .stb_i(cyc), .ack_o(ack), .scl_i(scl),
        .sda_i(sda), .scl_o(), .scl_oe_o(scl_oe), .sda_o(), .sda_oe_o(sda_oe));
    tfh_rmt_master i_tfh_rmt_master (.scl_i(scl), .sda_i(sda), .scl_rel_o(scl_rel),
        .sda_rel_o(sda_rel));
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic guard(input int n);
        if (n >= 3000) begin
            num_errors++;
            final_report();
        end
    endtask
    task automatic wb(input logic [3:0] a, input logic w, input logic [7:0] d);
        int n;
        @(posedge clk);
        adr <= a;
        we <= w;
        wdat <= {24'h00_0000, d};
        cyc <= 1'b1;
        for (n = 0; n < 3000 && ack !== 1'b1; n++)
            @(posedge clk);
        q = rdat[7:0];
        cyc <= 1'b0;
        guard(n);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
        wb(a, 1'b0, 8'h00);
        chk(q & m, exp);
    endtask
    task automatic wait_oe(input logic v);
        int n;
        for (n = 0; n < 3000 && scl_oe !== v; n++)
            @(posedge clk);
        guard(n);
    endtask
    task automatic t_regs();
        rd(`TFH_ADR_SSTAT, 8'hFF, 8'h00);
        wb(4'h2, 1'b1, 8'hFF);
        rd(4'h2, 8'hFF, 8'h00);
        wb(`TFH_ADR_CTRL, 1'b1, 8'h01);
        rd(`TFH_ADR_CTRL, 8'hFF, 8'h01);
    endtask
    task automatic t_frame();
        fork
            i_tfh_rmt_master.frame({`TFH_ADDR_DEF, 2'b01, 8'hA5, 1'b1}, a0);
            begin
                wait_oe(1'b1);
                rd(`TFH_ADR_SSTAT, 8'hA1, 8'hA1);
                wb(`TFH_ADR_SSTAT, 1'b1, 8'h00);
                rd(`TFH_ADR_SSTAT, 8'h80, 8'h80);
                chk(scl, 1'b0); // clock still held; safe moment to clear
                wb(`TFH_ADR_SSTAT, 1'b1, 8'h88); // stale collision cleared too
                rd(`TFH_ADR_SSTAT, 8'h88, 8'h00);
                wait_oe(1'b0);
                wait_oe(1'b1);
                rd(`TFH_ADR_SSTAT, 8'h40, 8'h40);
                wb(`TFH_ADR_SCMD, 1'b1, {6'h00, `TFH_CMD_RESP});
                rd(`TFH_ADR_SSTAT, 8'h40, 8'h00);
            end
        join
        chk(a0, 1'b0);
        rd(`TFH_ADR_SSTAT, 8'h08, 8'h00);
        rd(`TFH_ADR_MSTAT, 8'h03, {6'h00, `TFH_BS_IDLE});
        wb(`TFH_ADR_SSTAT, 1'b1, 8'h80);
        rd(`TFH_ADR_SSTAT, 8'h80, 8'h00);
        chk(scl, 1'b1);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_frame();
        final_report();
    end
endmodule // tb
